// file: logic/scc_sync_ctrl.sv
// serial-port controlled sync clock generator and configuration register block
//
// Overview of operation
// - wire-mode bit picks two-wire or three-wire readback
// - digital power-down freezes sync clock, port keeps running
// - detector input power-down drives buffer disable
// - crystal enable drives reference oscillator enable
// - sync clock is clock/4, disable tristates pin
// - automatic sync realigns sync clock to input
// - software sync bit advances one cycle, self-clears
// - hardware sync: input rising edge advances clock
// - in hardware sync, unlock sets sticky flag
// - shared pin outputs status unless sync mode
// - high speed bit changes automatic realign phase
// - converter power-down output
// - bandgap power-down output
// - internal resistor select output
// - rising-edge slew field output
// - falling-edge slew field output
// - sticky unlock cleared by first register read
`timescale 1ns/1ps
`include "scc_regs.svh"

module scc_sync_ctrl import scc_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // serial port
    input wire logic i_sclk,
    input wire logic i_csn,
    input wire logic i_sdio,
    output logic o_sdio_out,
    output logic o_sdio_oe_n,
    output logic o_sdo,
    // sync and status pins
    input wire logic i_sync_in,
    output logic o_status_out,
    output logic o_status_oe_n,
    output logic o_sync_clk,
    output logic o_sync_clk_oe_n,
    // loop lock detector
    input wire logic i_unlock,
    // configuration
    output scc_cfg_t o_cfg
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [4:0] meta_r;
    logic [4:0] pin_r;
    logic [4:0] pin_d_r;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_r <= 5'h08;
            pin_r <= 5'h08;
            pin_d_r <= 5'h08;
        end else begin
            meta_r <= {i_sclk, i_csn, i_sdio, i_sync_in, i_unlock};
            pin_r <= meta_r;
            pin_d_r <= pin_r;
        end
    end

    wire csn = pin_r[3];
    wire din = pin_r[2];
    wire unlock_lvl = pin_r[0];
    wire sclk_rise = pin_r[4] & ~pin_d_r[4];
    wire sclk_fall = ~pin_r[4] & pin_d_r[4];
    wire sync_rise = pin_r[1] & ~pin_d_r[1];
    wire unlock_rise = pin_r[0] & ~pin_d_r[0];

    ////////////////////////////////////////////////////////////////////////
    // serial port

    scc_sp_t sp_r;
    logic [5:0] cnt_r;
    logic rd_r;
    logic [4:0] addr_r;
    logic [39:0] sh_r;
    logic [31:0] ctl1_r;
    logic [39:0] ctl2_r;
    logic unlock_r;
    logic sw_adv_r;

    wire [39:0] sh_in = {sh_r[38:0], din};
    wire [4:0] instr_addr = sh_in[4:0];
    wire instr_rd = sh_in[`SCC_INSTR_RD];
    wire [5:0] len = (addr_r == `SCC_ADDR_CTL2) ? `SCC_LEN_CTL2 : `SCC_LEN_CTL1;
    wire instr_done = (sp_r == SP_INSTR) & sclk_rise & (cnt_r == `SCC_INSTR_BITS - 6'h01);
    wire data_last = (sp_r == SP_DATA) & sclk_rise & (cnt_r == len - 6'h01);
    wire wr_ctl1 = data_last & ~rd_r & (addr_r == `SCC_ADDR_CTL1);
    // commit only after the full frame of bytes has arrived
    wire wr_ctl2 = data_last & ~rd_r & (addr_r == `SCC_ADDR_CTL2);
    wire rd_ctl1 = instr_done & instr_rd & (instr_addr == `SCC_ADDR_CTL1);
    wire [31:0] ctl1_view = {ctl1_r[31:25], unlock_r, ctl1_r[23:0]};
    wire [39:0] rd_word = (instr_addr == `SCC_ADDR_CTL1) ? {ctl1_view, 8'h00} :
                          (instr_addr == `SCC_ADDR_CTL2) ? ctl2_r : 40'h0000000000;
    wire wire3 = ctl1_r[`SCC_B1_WIRE3];
    wire rd_drive = (sp_r == SP_DATA) & rd_r;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sp_r <= SP_IDLE;
            cnt_r <= 6'h00;
            rd_r <= 1'b0;
            addr_r <= 5'h00;
            sh_r <= 40'h0000000000;
        end else if (csn) begin
            sp_r <= SP_IDLE;
            cnt_r <= 6'h00;
        end else begin
            unique case (sp_r)
                SP_IDLE: begin
                    sp_r <= SP_INSTR;
                end
                SP_INSTR: begin
                    if (instr_done) begin
                        sp_r <= SP_DATA;
                        cnt_r <= 6'h00;
                        rd_r <= instr_rd;
                        addr_r <= instr_addr;
                        sh_r <= instr_rd ? rd_word : sh_in;
                    end else if (sclk_rise) begin
                        cnt_r <= cnt_r + 6'h01;
                        sh_r <= sh_in;
                    end
                end
                SP_DATA: begin
                    if (data_last) begin
                        sp_r <= SP_INSTR;
                        cnt_r <= 6'h00;
                    end else if (sclk_rise) begin
                        cnt_r <= cnt_r + 6'h01;
                    end
                    if (rd_r && sclk_fall) begin
                        sh_r <= {sh_r[38:0], 1'b0};
                    end else if (!rd_r && sclk_rise) begin
                        sh_r <= sh_in;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sdio_out <= 1'b0;
            o_sdio_oe_n <= 1'b1;
            o_sdo <= 1'b0;
        end else begin
            if (rd_drive && sclk_fall) begin
                o_sdio_out <= sh_r[39];
                o_sdo <= wire3 & sh_r[39];
            end
            o_sdio_oe_n <= ~(rd_drive & ~csn & ~wire3);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctl1_r <= `SCC_RST_CTL1;
            ctl2_r <= `SCC_RST_CTL2;
            sw_adv_r <= 1'b0;
        end else begin
            if (wr_ctl1) begin
                // open bits are not stored; self-clearing sync bit never held
                ctl1_r <= sh_in[31:0] & `SCC_MASK_CTL1;
            end
            if (wr_ctl2) begin
                ctl2_r <= sh_in & `SCC_MASK_CTL2;
            end
            sw_adv_r <= wr_ctl1 & sh_in[`SCC_B1_SW_SYNC];
        end
    end

    wire hw_sync = ctl1_r[`SCC_B1_HW_SYNC];
    wire auto_sync = ctl1_r[`SCC_B1_AUTO];
    wire dig_pd = ctl1_r[`SCC_B1_DIG_PD];
    wire unlock_set = unlock_rise & (hw_sync | auto_sync);
    wire unlock_nxt = unlock_set | (unlock_r & ~rd_ctl1);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            unlock_r <= 1'b0;
        end else begin
            unlock_r <= unlock_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sync clock divider and alignment

    logic [1:0] phase_r;

    wire hw_adv = hw_sync & sync_rise;
    wire auto_hit = auto_sync & ~hw_sync & sync_rise;
    wire [1:0] auto_phase = ctl1_r[`SCC_B1_HS_SYNC] ? `SCC_PH_AUTO_HS : `SCC_PH_AUTO;
    wire [1:0] step = (sw_adv_r | hw_adv) ? `SCC_PH_ADV : `SCC_PH_STEP;
    wire [1:0] phase_nxt = dig_pd ? phase_r :
                           auto_hit ? auto_phase : phase_r + step;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            phase_r <= 2'h0;
            o_sync_clk <= 1'b0;
            o_sync_clk_oe_n <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            o_sync_clk <= phase_nxt[1] & ~ctl1_r[`SCC_B1_SC_DIS];
            o_sync_clk_oe_n <= ctl1_r[`SCC_B1_SC_DIS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status pin and configuration outputs

    scc_cfg_t cfg_w;

    assign cfg_w.dig_pd = dig_pd;
    assign cfg_w.pfd_in_pd = ctl1_r[`SCC_B1_PFD_PD];
    assign cfg_w.xtal_en = ctl1_r[`SCC_B1_XTAL];
    assign cfg_w.auto_sync = auto_sync;
    assign cfg_w.hs_sync = ctl1_r[`SCC_B1_HS_SYNC];
    assign cfg_w.dac_pd = ctl2_r[`SCC_B2_DAC_PD];
    assign cfg_w.bg_pd = ctl2_r[`SCC_B2_BG_PD];
    assign cfg_w.int_rset = ctl2_r[`SCC_B2_INT_RSET];
    assign cfg_w.rise_slew = ctl2_r[`SCC_B2_RISE_HI:`SCC_B2_RISE_LO];
    assign cfg_w.fall_slew = ctl2_r[`SCC_B2_FALL_HI:`SCC_B2_FALL_LO];

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cfg <= '0;
            o_status_out <= 1'b0;
            o_status_oe_n <= 1'b0;
        end else begin
            o_cfg <= cfg_w;
            o_status_out <= unlock_lvl & ~(hw_sync | auto_sync);
            o_status_oe_n <= hw_sync | auto_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    property p_wire_mode;
        !o_sdio_oe_n |-> !wire3 && rd_r;
    endproperty
    a_wire_mode: assert property (p_wire_mode) else $error("data pin driven in three-wire mode");

    property p_dig_pd;
        dig_pd |=> phase_r == $past(phase_r);
    endproperty
    a_dig_pd: assert property (p_dig_pd) else $error("sync clock ran in power-down");

    property p_div4;
        !dig_pd && !auto_hit && !sw_adv_r && !hw_adv |=> phase_r == $past(phase_r) + 2'h1;
    endproperty
    a_div4: assert property (p_div4) else $error("sync clock divider step wrong");

    property p_gate;
        ctl1_r[`SCC_B1_SC_DIS] |=> o_sync_clk_oe_n && !o_sync_clk;
    endproperty
    a_gate: assert property (p_gate) else $error("sync clock not gated");

    property p_auto;
        auto_hit && !dig_pd |=> phase_r == $past(auto_phase);
    endproperty
    a_auto: assert property (p_auto) else $error("automatic realign phase wrong");

    sequence s_sw_write;
        wr_ctl1 && sh_in[`SCC_B1_SW_SYNC] && !dig_pd;
    endsequence
    sequence s_sw_advance;
        sw_adv_r && !ctl1_r[`SCC_B1_SW_SYNC];
    endsequence
    property p_sw_sync;
        s_sw_write |=> s_sw_advance ##1 !sw_adv_r;
    endproperty
    a_sw_sync: assert property (p_sw_sync) else $error("software sync not one-shot");

    property p_hw_sync;
        hw_adv && !dig_pd |=> phase_r == $past(phase_r) + 2'h2;
    endproperty
    a_hw_sync: assert property (p_hw_sync) else $error("hardware sync advance wrong");

    property p_unlock_set;
        unlock_set |=> unlock_r;
    endproperty
    a_unlock_set: assert property (p_unlock_set) else $error("unlock event lost");

    property p_status_pin;
        !hw_sync && !auto_sync |=> !o_status_oe_n;
    endproperty
    a_status_pin: assert property (p_status_pin) else $error("status pin not driven");

    property p_ctl2_frame;
        ctl2_r != $past(ctl2_r) |-> $past(wr_ctl2);
    endproperty
    a_ctl2_frame: assert property (p_ctl2_frame) else $error("second register changed mid-frame");

    property p_unlock_clr;
        rd_ctl1 && !unlock_set |=> !unlock_r;
    endproperty
    a_unlock_clr: assert property (p_unlock_clr) else $error("unlock flag not cleared by read");

endmodule

// file: logic/scc_regs.svh
// register offsets, field positions, masks and timing counts for sync clock control
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

`define SCC_ADDR_W 5
`define SCC_ADDR_CTL1 5'h00
`define SCC_ADDR_CTL2 5'h01
`define SCC_INSTR_BITS 6'h08
`define SCC_LEN_CTL1 6'h20
`define SCC_LEN_CTL2 6'h28
`define SCC_INSTR_RD 7

`define SCC_B1_UNLOCK 24
`define SCC_B1_WIRE3 14
`define SCC_B1_DIG_PD 7
`define SCC_B1_PFD_PD 6
`define SCC_B1_XTAL 5
`define SCC_B1_SC_DIS 4
`define SCC_B1_AUTO 3
`define SCC_B1_SW_SYNC 2
`define SCC_B1_HW_SYNC 1
`define SCC_B1_HS_SYNC 0

`define SCC_B2_DAC_PD 39
`define SCC_B2_BG_PD 33
`define SCC_B2_INT_RSET 32
`define SCC_B2_RISE_HI 31
`define SCC_B2_RISE_LO 29
`define SCC_B2_FALL_HI 28
`define SCC_B2_FALL_LO 26

`define SCC_MASK_CTL1 32'h000040FB
`define SCC_MASK_CTL2 40'h83FC000000
`define SCC_RST_CTL1 32'h00000000
`define SCC_RST_CTL2 40'h0000000000

`define SCC_PH_STEP 2'h1
`define SCC_PH_ADV 2'h2
`define SCC_PH_AUTO 2'h3
`define SCC_PH_AUTO_HS 2'h0

`endif

// file: logic/scc_pkg.sv
// types for sync clock and configuration control
package scc_pkg;

    typedef enum {SP_IDLE, SP_INSTR, SP_DATA} scc_sp_t;

    typedef struct packed {
        logic dig_pd;
        logic pfd_in_pd;
        logic xtal_en;
        logic auto_sync;
        logic hs_sync;
        logic dac_pd;
        logic bg_pd;
        logic int_rset;
        logic [2:0] rise_slew;
        logic [2:0] fall_slew;
    } scc_cfg_t;

endpackage

// file: dv/scc_host_model.sv
// serial port host model driving whole frames on the pins
`timescale 1ns/1ps
module scc_host_model (
    // system clock
    input wire logic i_clk,
    // serial pins
    output logic o_sclk,
    output logic o_csn,
    output logic o_sdio,
    output logic o_sdio_en,
    input wire logic i_sdio,
    input wire logic i_sdo
);
    initial begin
        o_sclk = 1'b0;
        o_csn = 1'b1;
        o_sdio = 1'b0;
        o_sdio_en = 1'b1;
    end
    // one frame: instruction then n data bits msb first, phases of 4 clocks
    task automatic xfer(input logic [7:0] ins, input logic [39:0] wd, input int n, input logic w3,
                        output logic [39:0] rd);
        logic [47:0] sh;
        sh = {ins, wd << (40 - n)};
        rd = '0;
        repeat (4) @(posedge i_clk);
        #1 o_csn = 1'b0;
        for (int i = 0; i < 8 + n; i++) begin
            repeat (4) @(posedge i_clk);
            #1 o_sclk = 1'b0;
            o_sdio = sh[47 - i];
            o_sdio_en = (i < 8) || !ins[7];
            repeat (4) @(posedge i_clk);
            if (i >= 8) rd = {rd[38:0], w3 ? i_sdo : i_sdio};
            #1 o_sclk = 1'b1;
        end
        repeat (4) @(posedge i_clk);
        #1 o_sclk = 1'b0;
        repeat (4) @(posedge i_clk);
        #1 o_csn = 1'b1;
        o_sdio_en = 1'b1;
    endtask
endmodule

// file: dv/sync_clock_and_config_control_test.sv
// self-checking bench for sync clock and configuration control
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin miscompares++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module sync_clock_and_config_control_test import scc_pkg::*;;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_unlock = 1'b0;
    logic sync_drv = 1'b0;
    logic w3 = 1'b0;
    logic sclk, csn, h_sdio, h_en, sdio_line, sync_line;
    logic o_sdio_out, o_sdio_oe_n, o_sdo, o_status_out, o_status_oe_n, o_sync_clk, o_sync_clk_oe_n;
    scc_cfg_t o_cfg;
    logic [39:0] rd;
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    int last_rise = 0;
    int r0;
    int oe_cnt = 0;
    logic sc_d = 1'b0;
    always #20 i_clk = ~i_clk;
    // pulled-up data line and shared sync pin
    assign sdio_line = !o_sdio_oe_n ? o_sdio_out : (h_en ? h_sdio : 1'b1);
    assign sync_line = !o_status_oe_n ? o_status_out : sync_drv;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        sc_d <= o_sync_clk;
        if (o_sdio_oe_n === 1'b0) oe_cnt <= oe_cnt + 1;
        if (o_sync_clk === 1'b1 && sc_d === 1'b0) last_rise <= cyc;
    end
    scc_host_model host (.i_clk(i_clk), .o_sclk(sclk), .o_csn(csn), .o_sdio(h_sdio), .o_sdio_en(h_en),
                         .i_sdio(sdio_line), .i_sdo(o_sdo));
    scc_sync_ctrl DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_sclk(sclk), .i_csn(csn), .i_sdio(sdio_line),
        .o_sdio_out(o_sdio_out), .o_sdio_oe_n(o_sdio_oe_n), .o_sdo(o_sdo), .i_sync_in(sync_line),
        .o_status_out(o_status_out), .o_status_oe_n(o_status_oe_n), .o_sync_clk(o_sync_clk),
        .o_sync_clk_oe_n(o_sync_clk_oe_n), .i_unlock(i_unlock), .o_cfg(o_cfg));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic scc_cfg_t mkcfg(logic [31:0] c1, logic [39:0] c2);
        return scc_cfg_t'{c1[7], c1[6], c1[5], c1[3], c1[0], c2[39], c2[33], c2[32], c2[31:29], c2[28:26]};
    endfunction
    task automatic wr1(input logic [31:0] d);
        host.xfer(8'h00, {8'h00, d}, 32, w3, rd);
    endtask
    task automatic wr2(input logic [39:0] d);
        host.xfer(8'h01, d, 40, w3, rd);
    endtask
    task automatic rdr(input logic [4:0] a, input int n);
        host.xfer({3'h4, a}, 40'h0, n, w3, rd);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK("cfg", mkcfg(32'h0, 40'h0), o_cfg)
        `CHK("sync_oe_n", 1'b0, o_sync_clk_oe_n)
        `CHK("status_oe_n", 1'b0, o_status_oe_n)
        `CHK("sdio_oe_n", 1'b1, o_sdio_oe_n)
    endtask
    task automatic t_cfg();
        wr1(32'h0000_0061);
        `CHK("cfg1", mkcfg(32'h61, 40'h0), o_cfg)
        r0 = oe_cnt;
        rdr(5'h00, 32);
        `CHK("rd1", 40'h61, rd)
        `CHK("wire2_oe", 1'b1, oe_cnt > r0)
        wr2(40'h83FC000000);
        `CHK("cfg2", mkcfg(32'h61, 40'h83FC000000), o_cfg)
        rdr(5'h01, 40);
        `CHK("rd2", 40'h83FC000000, rd)
        wr2(40'h80A4000000);
        `CHK("cfg3", mkcfg(32'h61, 40'h80A4000000), o_cfg)
        rdr(5'h05, 32);
        `CHK("rd_unmapped", 40'h0, rd)
        wr2(40'h0);
        wr1(32'h0);
    endtask
    task automatic t_sync();
        r0 = last_rise;
        waitc(4);
        `CHK("period", r0 + 4, last_rise)
        wr1(32'h4);
        wr1(32'h4);
        waitc(8);
        `CHK("sw_adv", 2, (last_rise - r0) % 4)
        rdr(5'h00, 32);
        `CHK("sw_clear", 40'h0, rd)
        wr1(32'h2);
        `CHK("hw_oe_n", 1'b1, o_status_oe_n)
        r0 = last_rise;
        sync_drv = 1'b1;
        waitc(4);
        sync_drv = 1'b0;
        waitc(8);
        `CHK("hw_adv", 3, (last_rise - r0) % 4)
        i_unlock = 1'b1;
        waitc(4);
        i_unlock = 1'b0;
        rdr(5'h00, 32);
        `CHK("sticky", 40'h01000002, rd)
        rdr(5'h00, 32);
        `CHK("sticky_clr", 40'h2, rd)
        wr1(32'h9);
        `CHK("auto_oe_n", 1'b1, o_status_oe_n)
        `CHK("auto_cfg", mkcfg(32'h9, 40'h0), o_cfg)
        r0 = cyc;
        sync_drv = 1'b1;
        waitc(4);
        sync_drv = 1'b0;
        waitc(8);
        `CHK("auto_hs", 1, (last_rise - r0) % 4)
        wr1(32'h8);
        r0 = cyc;
        sync_drv = 1'b1;
        waitc(4);
        sync_drv = 1'b0;
        waitc(8);
        `CHK("auto_align", 2, (last_rise - r0) % 4)
        wr1(32'h0);
        i_unlock = 1'b1;
        waitc(4);
        `CHK("status", 2'b01, {o_status_oe_n, o_status_out})
        i_unlock = 1'b0;
    endtask
    task automatic t_modes();
        wr1(32'h80);
        waitc(4);
        r0 = last_rise;
        waitc(8);
        `CHK("pd_freeze", r0, last_rise)
        rdr(5'h00, 32);
        `CHK("pd_port", 40'h80, rd)
        wr1(32'h10);
        `CHK("sc_dis", 2'b10, {o_sync_clk_oe_n, o_sync_clk})
        wr1(32'h4000);
        w3 = 1'b1;
        r0 = oe_cnt;
        rdr(5'h00, 32);
        `CHK("wire3_rd", 40'h4000, rd)
        `CHK("wire3_oe", 0, oe_cnt - r0)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        waitc(16);
        i_rstn = 1'b1;
        waitc(4);
        t_reset();
        t_cfg();
        t_sync();
        t_modes();
        tally_and_finish();
    end
endmodule
